//--- tss_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"

// Function
// - Four serial inputs and outputs, 32 channels
// - Any input channel to any output channel
// - Processor reads inputs, writes outputs
// - Frame pulse low resets counter next fall
// - Bit cell is two clock periods
// - Read/write high reads, low writes
// - Chip select low selects, high ignored
// - Access only with strobe and select
// - Acknowledge pulled low when access done
// - Drive gate low floats all outputs
// - Per-channel float under software control
// - Data bus driven only during reads
// - Six-bit address plus control register bits selects each location
// - Top address bit picks control or memory
// - Frames of 32 eight-bit channels
// - Low entry addresses data memory when switched
// - High entry selects message mode, drive
module tss_switch (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic bit_clock_4m_n_i,
  input wire logic frame_pulse_n_i,
  input wire logic serial_drive_gate_i,
  input wire logic [3:0] serial_in_lines_i,
  output logic [3:0] serial_out_lines_o,
  output logic [3:0] serial_out_oe_o,
  tss_if.dev bus
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [23:0] pin_raw;
  logic [23:0] s1_q;
  logic [23:0] s2_q;
  logic [23:0] s3_q;
  logic [23:0] pin_q;
  logic [3:0] si;
  logic c4;
  logic fp_n;
  logic serial_drive_gate;
  logic stb;
  logic cs_n;
  logic rw;
  logic [5:0] addr;
  logic [7:0] dbus;

  assign pin_raw = {bus.host_data_bus, bus.host_addr_lines,
                    bus.read_not_write, bus.chip_sel_n,
                    bus.transfer_strobe, serial_drive_gate_i,
                    frame_pulse_n_i, bit_clock_4m_n_i, serial_in_lines_i};

  // A level moves only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= 24'h00_0000;
      s2_q <= 24'h00_0000;
      s3_q <= 24'h00_0000;
      pin_q <= 24'h00_0000;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  assign si = pin_q[3:0];
  assign c4 = pin_q[4];
  assign fp_n = pin_q[5];
  assign serial_drive_gate = pin_q[6];
  assign stb = pin_q[7];
  assign cs_n = pin_q[8];
  assign rw = pin_q[9];
  assign addr = pin_q[15:10];
  assign dbus = pin_q[23:16];

  // ****************************************************************
  // Frame timing
  // ****************************************************************
  // cnt: [8:4] channel, [3:1] bit, [0] half bit cell
  logic c4_prev_q;
  logic c4_fall;
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  assign c4_fall = c4_prev_q & ~c4;
  assign cnt_d = fp_n ? cnt_q + 9'h001 : 9'h000;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      c4_prev_q <= 1'b0;
      cnt_q <= 9'h000;
    end else begin
      c4_prev_q <= c4;
      if (c4_fall) begin
        cnt_q <= cnt_d;
      end
    end
  end

  // ****************************************************************
  // Memories
  // ****************************************************************
  logic [7:0] dmem [128];
  logic [7:0] cml [128];
  logic [7:0] cmh [128];
  logic [7:0] in_byte [4];
  logic [7:0] ctrl_q;

  // Byte written as its last bit lands, a frame ahead of reuse
  always_ff @(posedge clk_i) begin
    if (c4_fall && cnt_d[3:0] == `TSS_LAST_HALF_BIT) begin
      for (int i = 0; i < `TSS_NUM_STREAMS; i++) begin
        dmem[{2'(i), cnt_d[8:4]}] <= in_byte[i];
      end
    end
  end

  // ****************************************************************
  // Serial streams
  // ****************************************************************
  for (genvar g = 0; g < `TSS_NUM_STREAMS; g++) begin : g_stream
    logic [7:0] in_sh_q;
    logic [7:0] out_sh_q;
    logic slot_en_q;
    logic [6:0] oidx;
    logic msg;
    logic en;
    logic [7:0] tx_byte;

    assign in_byte[g] = {in_sh_q[6:0], si[g]};

    // Sample mid-cell, MSB first
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        in_sh_q <= 8'h00;
      end else if (c4_fall && cnt_d[0]) begin
        in_sh_q <= in_byte[g];
      end
    end

    assign oidx = {2'(g), cnt_d[8:4]};
    assign msg = ctrl_q[`TSS_CR_BCAST] | cmh[oidx][`TSS_CMH_MSG];
    assign en = ctrl_q[`TSS_CR_BCAST] | cmh[oidx][`TSS_CMH_OE];
    // Any stream may pull any input byte: no blocking
    assign tx_byte = msg ? cml[oidx] : dmem[cml[oidx][6:0]];

    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        out_sh_q <= 8'h00;
        slot_en_q <= 1'b0;
      end else if (c4_fall) begin
        if (cnt_d[3:0] == `TSS_FIRST_HALF_BIT) begin
          out_sh_q <= tx_byte;
          slot_en_q <= en;
        end else if (!cnt_d[0]) begin
          out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
      end
    end

    assign serial_out_lines_o[g] = out_sh_q[7];
    assign serial_out_oe_o[g] = slot_en_q & serial_drive_gate;
  end

  // ****************************************************************
  // Processor interface
  // ****************************************************************
  tss_pkg::tss_dev_state_t state_q;
  logic sel;
  logic [6:0] mem_idx;
  logic [1:0] msel;
  logic split;
  logic wr_now;
  logic [7:0] rd_val;
  logic [7:0] rd_q;
  logic ack_q;
  logic drv_q;

  assign sel = stb & ~cs_n;
  assign mem_idx = {ctrl_q[`TSS_CR_STREAM_HI:`TSS_CR_STREAM_LO],
                    addr[4:0]};
  assign msel = ctrl_q[`TSS_CR_MSEL_HI:`TSS_CR_MSEL_LO];
  assign split = ctrl_q[`TSS_CR_SPLIT];
  assign wr_now = (state_q == tss_pkg::TSS_DEV_ACCESS) & ~rw;

  always_comb begin
    rd_val = 8'h00;
    if (!addr[`TSS_ADDR_MEM]) begin
      rd_val = ctrl_q;
    end else if (split || msel == `TSS_MSEL_DMEM) begin
      rd_val = dmem[mem_idx];
    end else if (msel == `TSS_MSEL_CML) begin
      rd_val = cml[mem_idx];
    end else if (msel == `TSS_MSEL_CMH) begin
      rd_val = cmh[mem_idx];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= tss_pkg::TSS_DEV_IDLE;
    end else begin
      case (state_q)
        tss_pkg::TSS_DEV_IDLE: begin
          if (sel) begin
            state_q <= tss_pkg::TSS_DEV_ACCESS;
          end
        end
        tss_pkg::TSS_DEV_ACCESS: begin
          state_q <= tss_pkg::TSS_DEV_ACK;
        end
        tss_pkg::TSS_DEV_ACK: begin
          if (!sel) begin
            state_q <= tss_pkg::TSS_DEV_IDLE;
          end
        end
        default: begin
          state_q <= tss_pkg::TSS_DEV_IDLE;
        end
      endcase
    end
  end

  // Acknowledge and, on reads only, data drive rise together and fall together
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      rd_q <= 8'h00;
    end else if (state_q == tss_pkg::TSS_DEV_ACCESS) begin
      ack_q <= 1'b1;
      drv_q <= rw;
      rd_q <= rd_val;
    end else if (state_q != tss_pkg::TSS_DEV_ACK || !sel) begin
      ack_q <= 1'b0;
      drv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `TSS_CR_RESET;
    end else if (wr_now && !addr[`TSS_ADDR_MEM]) begin
      ctrl_q <= dbus;
    end
  end

  // Split mode steers every memory write to the low entries
  always_ff @(posedge clk_i) begin
    if (wr_now && addr[`TSS_ADDR_MEM] &&
        (split || msel == `TSS_MSEL_CML)) begin
      cml[mem_idx] <= dbus;
    end
  end

  // Reset leaves every channel floating and switched
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 128; i++) begin
        cmh[i] <= `TSS_CMH_RESET;
      end
    end else if (wr_now && addr[`TSS_ADDR_MEM] && !split &&
                 msel == `TSS_MSEL_CMH) begin
      cmh[mem_idx] <= dbus;
    end
  end

  assign bus.dev_data = rd_q;
  assign bus.dev_data_oe = drv_q;
  assign bus.transfer_ack_oe = ack_q;
endmodule // tss_switch

`default_nettype wire

//--- tss_cfg.svh
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// ****************************************************************
// Frame geometry
// ****************************************************************
`define TSS_NUM_STREAMS 4
`define TSS_NUM_CHANNELS 32
`define TSS_LAST_HALF_BIT 4'hF
`define TSS_FIRST_HALF_BIT 4'h0

// ****************************************************************
// Control register layout
// ****************************************************************
`define TSS_CR_RESET 8'h00
`define TSS_CR_SPLIT 7
`define TSS_CR_BCAST 6
`define TSS_CR_MSEL_HI 4
`define TSS_CR_MSEL_LO 3
`define TSS_CR_STREAM_HI 1
`define TSS_CR_STREAM_LO 0
`define TSS_MSEL_DMEM 2'h1
`define TSS_MSEL_CML 2'h2
`define TSS_MSEL_CMH 2'h3

// ****************************************************************
// Connection memory high bits and bus
// ****************************************************************
`define TSS_CMH_OE 0
`define TSS_CMH_MSG 2
`define TSS_CMH_RESET 8'h00
`define TSS_ADDR_MEM 5
`define TSS_BUS_IDLE 8'hFF
`define TSS_FIFO_DEPTH 8

`endif

//--- tss_pkg.sv
package tss_pkg;

  typedef enum logic [1:0] {
    TSS_DEV_IDLE = 2'b00,
    TSS_DEV_ACCESS = 2'b01,
    TSS_DEV_ACK = 2'b10
  } tss_dev_state_t;

  typedef enum logic [1:0] {
    TSS_HOST_IDLE = 2'b00,
    TSS_HOST_SETUP = 2'b01,
    TSS_HOST_WAIT = 2'b10,
    TSS_HOST_RELEASE = 2'b11
  } tss_host_state_t;

  typedef struct packed {
    logic write;
    logic [5:0] addr;
    logic [7:0] data;
  } tss_cmd_t;

endpackage

//--- tss_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"

interface tss_if;
  logic transfer_strobe;
  logic chip_sel_n;
  logic read_not_write;
  logic [5:0] host_addr_lines;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic [7:0] host_wdata;
  logic host_data_oe;
  logic transfer_ack_oe;
  logic [7:0] host_data_bus;
  logic transfer_ack_n;

  // Pull-ups stand in for undriven wires
  assign host_data_bus = dev_data_oe ? dev_data :
                         (host_data_oe ? host_wdata : `TSS_BUS_IDLE);
  assign transfer_ack_n = ~transfer_ack_oe;

  modport dev (
    input transfer_strobe,
    input chip_sel_n,
    input read_not_write,
    input host_addr_lines,
    input host_data_bus,
    output dev_data,
    output dev_data_oe,
    output transfer_ack_oe
  );

  modport host (
    output transfer_strobe,
    output chip_sel_n,
    output read_not_write,
    output host_addr_lines,
    output host_wdata,
    output host_data_oe,
    input host_data_bus,
    input transfer_ack_n
  );
endinterface // tss_if

`default_nettype wire

//--- tss_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module tss_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers wrap only for power-of-two depths
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tss_fifo

`default_nettype wire

//--- tss_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tss_cfg.svh"

module tss_host (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic [5:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  tss_if.host bus
);
  tss_pkg::tss_host_state_t state_q;
  tss_pkg::tss_cmd_t cmd_in;
  tss_pkg::tss_cmd_t cmd_out;
  logic cmd_avail;
  logic take;
  logic a1_q;
  logic a2_q;
  logic a3_q;
  logic ack_n_q;
  logic stb_q;
  logic cs_n_q;
  logic rw_q;
  logic [5:0] addr_q;
  logic [7:0] wd_q;
  logic doe_q;
  logic rsp_v_q;
  logic [7:0] rsp_d_q;

  // ****************************************************************
  // Command queue
  // ****************************************************************
  assign cmd_in = '{write: cmd_write_i, addr: cmd_addr_i,
                    data: cmd_wdata_i};
  assign take = cmd_avail & (state_q == tss_pkg::TSS_HOST_IDLE);

  tss_fifo #(
    .WIDTH($bits(tss_pkg::tss_cmd_t)),
    .DEPTH(`TSS_FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .in_data_i(cmd_in),
    .out_valid_o(cmd_avail),
    .out_ready_i(take),
    .out_data_o(cmd_out)
  );

  // ****************************************************************
  // Bus cycle
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a1_q <= 1'b1;
      a2_q <= 1'b1;
      a3_q <= 1'b1;
      ack_n_q <= 1'b1;
    end else begin
      a1_q <= bus.transfer_ack_n;
      a2_q <= a1_q;
      a3_q <= a2_q;
      if (a2_q == a3_q) begin
        ack_n_q <= a3_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= tss_pkg::TSS_HOST_IDLE;
      stb_q <= 1'b0;
      cs_n_q <= 1'b1;
      rw_q <= 1'b1;
      addr_q <= 6'h00;
      wd_q <= 8'h00;
      doe_q <= 1'b0;
      rsp_v_q <= 1'b0;
      rsp_d_q <= 8'h00;
    end else begin
      rsp_v_q <= 1'b0;
      case (state_q)
        tss_pkg::TSS_HOST_IDLE: begin
          if (take) begin
            cs_n_q <= 1'b0;
            rw_q <= ~cmd_out.write;
            addr_q <= cmd_out.addr;
            wd_q <= cmd_out.data;
            doe_q <= cmd_out.write;
            state_q <= tss_pkg::TSS_HOST_SETUP;
          end
        end
        tss_pkg::TSS_HOST_SETUP: begin
          stb_q <= 1'b1;
          state_q <= tss_pkg::TSS_HOST_WAIT;
        end
        tss_pkg::TSS_HOST_WAIT: begin
          // Read data has stood for cycles before the synced ack
          if (!ack_n_q) begin
            stb_q <= 1'b0;
            cs_n_q <= 1'b1;
            doe_q <= 1'b0;
            rsp_v_q <= rw_q;
            rsp_d_q <= bus.host_data_bus;
            state_q <= tss_pkg::TSS_HOST_RELEASE;
          end
        end
        tss_pkg::TSS_HOST_RELEASE: begin
          if (ack_n_q) begin
            state_q <= tss_pkg::TSS_HOST_IDLE;
          end
        end
        default: begin
          state_q <= tss_pkg::TSS_HOST_IDLE;
        end
      endcase
    end
  end

  assign bus.transfer_strobe = stb_q;
  assign bus.chip_sel_n = cs_n_q;
  assign bus.read_not_write = rw_q;
  assign bus.host_addr_lines = addr_q;
  assign bus.host_wdata = wd_q;
  assign bus.host_data_oe = doe_q;
  assign rsp_valid_o = rsp_v_q;
  assign rsp_rdata_o = rsp_d_q;
endmodule // tss_host

`default_nettype wire

//--- tss_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tss_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic transfer_strobe,
  input wire logic chip_sel_n,
  input wire logic read_not_write,
  input wire logic [5:0] host_addr_lines,
  input wire logic dev_data_oe,
  input wire logic host_data_oe,
  input wire logic transfer_ack_oe
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  sequence s_sel_req;
    !chip_sel_n && transfer_strobe;
  endsequence

  sequence s_desel;
    chip_sel_n [*8];
  endsequence

  chk_ack_needs_sel: assert property (
    $rose(transfer_ack_oe) |-> $past(!chip_sel_n && transfer_strobe, 3))
    else $error("ack raised without a selected strobe");
  chk_ack_in_time: assert property (
    $rose(transfer_strobe) && !chip_sel_n |-> ##[3:14] transfer_ack_oe)
    else $error("ack late after strobe");
  chk_ack_holds: assert property (
    (transfer_ack_oe and s_sel_req) |=> transfer_ack_oe)
    else $error("ack dropped while strobe still held");
  chk_ack_release: assert property (
    $fell(transfer_strobe) |-> ##[1:12] !transfer_ack_oe)
    else $error("ack not released after strobe");
  chk_desel_quiet: assert property (
    s_desel |-> !transfer_ack_oe && !dev_data_oe)
    else $error("device active while deselected");
  chk_drive_on_read: assert property (
    $rose(dev_data_oe) |-> read_not_write && transfer_ack_oe)
    else $error("data driven outside a read");
  chk_drive_release: assert property (
    $fell(dev_data_oe) |-> $fell(transfer_ack_oe))
    else $error("data drive and ack not released together");
  chk_no_bus_fight: assert property (
    !(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  chk_request_stable: assert property (
    transfer_strobe && $past(transfer_strobe) |->
      $stable(host_addr_lines) && $stable(read_not_write))
    else $error("request changed while strobe held");
  chk_strobe_setup: assert property (
    $rose(transfer_strobe) |-> !chip_sel_n && $stable(host_addr_lines))
    else $error("strobe without select or stable address");
endmodule // tss_assertions

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_i, rst_n_i, bclk_n, frame_n, gate, saw_full;
  logic [3:0] sin, sout, soe;
  logic cmd_valid, cmd_ready, cmd_write, rsp_valid;
  logic [5:0] cmd_addr;
  logic [7:0] cmd_wdata, rsp_rdata, b;
  logic [7:0] rxb [4][32];
  logic rxoe [4][32];
  logic [8:0] cnt;
  int miscompares, checks_done, frame_no, div;

  tss_if bus_if ();
  tss_switch tss_switch_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bit_clock_4m_n_i(bclk_n), .frame_pulse_n_i(frame_n),
    .serial_drive_gate_i(gate), .serial_in_lines_i(sin),
    .serial_out_lines_o(sout), .serial_out_oe_o(soe), .bus(bus_if.dev));
  tss_host tss_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .bus(bus_if.host));
  tss_assertions tss_assertions_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .transfer_strobe(bus_if.transfer_strobe),
    .chip_sel_n(bus_if.chip_sel_n), .read_not_write(bus_if.read_not_write),
    .host_addr_lines(bus_if.host_addr_lines),
    .dev_data_oe(bus_if.dev_data_oe), .host_data_oe(bus_if.host_data_oe),
    .transfer_ack_oe(bus_if.transfer_ack_oe));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Serial side
  // ****************************************************************
  function automatic logic [7:0] pat(input int s, input int c);
    return {s[1:0], c[4:0], 1'b1};
  endfunction

  // Bit clock of 12 system cycles keeps a frame short yet outruns sync lag
  always @(negedge clk_i) begin
    div = div + 1;
    if (div == 6) begin
      div = 0;
      bclk_n = ~bclk_n;
      if (bclk_n) begin
        frame_n = (cnt != 9'h1FF);
      end else begin
        cnt = frame_n ? cnt + 9'h001 : 9'h000;
        for (int s = 0; s < 4; s++) begin
          b = pat(s, int'(cnt[8:4]));
          if (!cnt[0]) begin
            sin[s] = b[3'd7 - cnt[3:1]];
          end else begin
            rxb[s][cnt[8:4]][3'd7 - cnt[3:1]] = sout[s];
            if (cnt[3:1] == 3'd0) rxoe[s][cnt[8:4]] = soe[s];
          end
        end
        if (cnt == 9'h1FF) frame_no++;
      end
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Leaves valid high so back-to-back pushes fill the queue
  task automatic push(input logic w, input logic [5:0] a,
                      input logic [7:0] d);
    @(negedge clk_i);
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge clk_i);
    end
    @(posedge clk_i);
  endtask

  task automatic idle;
    @(negedge clk_i);
    cmd_valid = 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    push(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    int n;
    n = 0;
    push(1'b0, a, 8'h00);
    idle;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 4000) miscompares++;
    @(negedge clk_i);
    cmp8(rsp_rdata, e);
  endtask

  task automatic wait_frames(input int k);
    int t;
    idle;
    t = frame_no + k;
    while (frame_no < t) @(negedge clk_i);
  endtask

  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    end_sim;
  end

  initial begin
    rst_n_i = 1'b0;
    bclk_n = 1'b1;
    frame_n = 1'b1;
    gate = 1'b1;
    sin = 4'h0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 6'h00;
    cmd_wdata = 8'h00;
    div = 0;
    cnt = 9'h1FF;
    saw_full = 1'b0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(6'h00, 8'h00);
    for (int i = 0; i < 10; i++) wr(6'h00, (i == 9) ? 8'h03 : 8'h00);
    idle;
    cmp1(saw_full, 1'b1);
    rd(6'h1F, 8'h03);
    wr(6'h00, 8'h18);
    wr(6'h23, 8'h05);
    wr(6'h00, 8'h10);
    wr(6'h23, 8'hC3);
    wr(6'h00, 8'h19);
    wr(6'h27, 8'h01);
    wr(6'h00, 8'h11);
    wr(6'h27, 8'h54);
    wr(6'h00, 8'h12);
    wr(6'h25, 8'h3C);
    wr(6'h00, 8'h11);
    rd(6'h27, 8'h54);
    wr(6'h00, 8'h18);
    rd(6'h23, 8'h05);
    wait_frames(2);
    wr(6'h00, 8'h0A);
    rd(6'h34, pat(2, 20));
    cmp8(rxb[0][3], 8'hC3);
    cmp1(rxoe[0][3], 1'b1);
    cmp8(rxb[1][7], pat(2, 20));
    cmp1(rxoe[1][7], 1'b1);
    cmp1(rxoe[2][5], 1'b0);
    gate = 1'b0;
    wait_frames(2);
    cmp1(rxoe[0][3], 1'b0);
    gate = 1'b1;
    wr(6'h00, 8'h40);
    rd(6'h00, 8'h40);
    wait_frames(2);
    cmp8(rxb[2][5], 8'h3C);
    cmp1(rxoe[2][5], 1'b1);
    cmp8(rxb[0][3], 8'hC3);
    // Split mode: reads from data memory, writes to low entries
    wr(6'h00, 8'h82);
    wr(6'h26, 8'h5A);
    rd(6'h34, pat(2, 20));
    wr(6'h00, 8'h12);
    rd(6'h26, 8'h5A);
    end_sim;
  end
endmodule // tb_top

`default_nettype wire
